// ### clk_delay_consts.svh
// Constants of the sample clock delay control register bank.
// Included by the package and the design; definitions only.
`ifndef CLK_DELAY_CONSTS_SVH
`define CLK_DELAY_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_CLOCK_DELAY_MODE 10'h110
`define IDX_SUPERFINE_DELAY_STEPS 10'h111
`define IDX_FINE_DELAY_STEPS 10'h112
`define IDX_CLOCK_STATE 10'h11B

// Field positions
`define MODE_LSB 0
`define MODE_MSB 2
`define CLOCK_DETECT_BIT 0

// Reset values
`define RST_MODE 3'h0
`define RST_SUPERFINE 8'h00
`define RST_FINE 8'hC0

// Mode codes
`define MODE_NONE 3'h0
`define MODE_FINE_LIMITED 3'h2
`define MODE_FINE_LOW_JITTER 3'h3
`define MODE_FINE_FULL 3'h4
`define MODE_FINE_SUPERFINE 3'h6

// Step counts
`define FINE_LIMITED_MAX 16
`define FINE_MAX 192
`define SUPERFINE_MAX 128

// Step sizes in femtoseconds
`define FINE_STEP_FS 1725
`define SUPERFINE_STEP_FS 250

`endif

// ### clk_delay_pkg.sv
// Types shared by the sample clock delay control block.
// Assumes clk_delay_consts.svh sits in the same folder.
package clk_delay_pkg;
  `include "clk_delay_consts.svh"

  // Settings driven to the analog delay line
  typedef struct packed {
    logic fine_en;
    logic superfine_en;
    logic low_jitter;
    logic [7:0] fine_steps;
    logic [7:0] superfine_steps;
    logic [18:0] delay_fs;
  } delay_cfg_t;
endpackage

// ### sample_clock_delay_control.sv
// Sample clock delay control register bank behind an AHB-Lite slave port.
// Assumes a single-master AHB-Lite bus on clk, word transfers only,
// and a clock detect level already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "clk_delay_consts.svh"

module sample_clock_delay_control #(
  parameter int ADDR_W = 12,
  parameter int FINE_MAX = `FINE_MAX,
  parameter int FINE_LIMITED_MAX = `FINE_LIMITED_MAX,
  parameter int SUPERFINE_MAX = `SUPERFINE_MAX
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic clock_detected,
  output clk_delay_pkg::delay_cfg_t delay_cfg
);
  import clk_delay_pkg::*;

  initial begin
    if (ADDR_W < 12 || ADDR_W > 32)
      $error("ADDR_W must lie between 12 and 32");
    if (FINE_MAX < 1 || FINE_MAX > 255 || FINE_LIMITED_MAX > FINE_MAX)
      $error("Fine step limits out of range");
    if (SUPERFINE_MAX < 1 || SUPERFINE_MAX > 255)
      $error("Superfine step limit out of range");
  end

  localparam logic [7:0] FINE_MAX_B = 8'(FINE_MAX);
  localparam logic [7:0] FINE_LIM_B = 8'(FINE_LIMITED_MAX);
  localparam logic [7:0] SF_MAX_B = 8'(SUPERFINE_MAX);

  function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[11:2];
  endfunction

  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lim);
    clamp8 = (v > lim) ? lim : v;
  endfunction

  // Bus stage: address phase captured, write completes in data phase
  logic wr_pend_q, wr_pend_d;
  logic [9:0] wr_idx_q, wr_idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic addr_phase;

  // Register group
  logic [2:0] mode_q, mode_d;
  logic [7:0] superfine_q, superfine_d;
  logic [7:0] fine_q, fine_d;

  // Output group
  delay_cfg_t cfg_q, cfg_d;

  assign addr_phase = hsel && htrans[1] && hready;
  // Zero wait states; the bank never stalls or errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign delay_cfg = cfg_q;

  always_comb begin
    logic [9:0] idx;
    idx = word_index(haddr);
    wr_pend_d = addr_phase && hwrite;
    wr_idx_d = addr_phase ? idx : wr_idx_q;
    rdata_d = rdata_q;
    if (addr_phase && !hwrite) begin
      // Read of a register written in the previous data phase sees the new value
      if (idx == `IDX_CLOCK_DELAY_MODE) begin
        rdata_d = {29'h0000000, mode_d};
      end else if (idx == `IDX_SUPERFINE_DELAY_STEPS) begin
        rdata_d = {24'h000000, superfine_d};
      end else if (idx == `IDX_FINE_DELAY_STEPS) begin
        rdata_d = {24'h000000, fine_d};
      end else if (idx == `IDX_CLOCK_STATE) begin
        rdata_d = {31'h00000000, clock_detected};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 10'h000;
      rdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    mode_d = mode_q;
    superfine_d = superfine_q;
    fine_d = fine_q;
    if (wr_pend_q) begin
      if (wr_idx_q == `IDX_CLOCK_DELAY_MODE) begin
        // Upper bits are reserved and read back zero
        mode_d = hwdata[`MODE_MSB:`MODE_LSB];
      end else if (wr_idx_q == `IDX_SUPERFINE_DELAY_STEPS) begin
        superfine_d = hwdata[7:0];
      end else if (wr_idx_q == `IDX_FINE_DELAY_STEPS) begin
        fine_d = hwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `RST_MODE;
      superfine_q <= `RST_SUPERFINE;
      fine_q <= `RST_FINE;
    end else begin
      mode_q <= mode_d;
      superfine_q <= superfine_d;
      fine_q <= fine_d;
    end
  end

  // Applied settings; values beyond a mode's valid range are clamped
  // so that a software slip cannot push the line past its end.
  always_comb begin
    logic [7:0] f;
    logic [7:0] s;
    f = 8'h00;
    s = 8'h00;
    cfg_d.fine_en = 1'b0;
    cfg_d.superfine_en = 1'b0;
    cfg_d.low_jitter = 1'b0;
    case (mode_q)
      `MODE_FINE_LIMITED: begin
        cfg_d.fine_en = 1'b1;
        f = clamp8(fine_q, FINE_LIM_B);
        // Superfine also applies in this code
        cfg_d.superfine_en = 1'b1;
        s = clamp8(superfine_q, SF_MAX_B);
      end
      `MODE_FINE_LOW_JITTER: begin
        cfg_d.fine_en = 1'b1;
        cfg_d.low_jitter = 1'b1;
        f = clamp8(fine_q, FINE_LIM_B);
      end
      `MODE_FINE_FULL: begin
        cfg_d.fine_en = 1'b1;
        f = clamp8(fine_q, FINE_MAX_B);
      end
      `MODE_FINE_SUPERFINE: begin
        cfg_d.fine_en = 1'b1;
        cfg_d.superfine_en = 1'b1;
        f = clamp8(fine_q, FINE_MAX_B);
        s = clamp8(superfine_q, SF_MAX_B);
      end
      // No delay, and reserved codes behave as no delay
      default: begin
        f = 8'h00;
      end
    endcase
    cfg_d.fine_steps = f;
    cfg_d.superfine_steps = s;
    cfg_d.delay_fs = 19'(f * `FINE_STEP_FS) + 19'(s * `SUPERFINE_STEP_FS);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

endmodule

`default_nettype wire

// ### scdc_sva.sv
// Checker on the delay settings of the clock delay bank.
// Bound into sample_clock_delay_control; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module scdc_sva #(parameter int ADDR_W = 12) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire clk_delay_pkg::delay_cfg_t delay_cfg
);
  import clk_delay_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  delay_cfg_t c;
  logic [2:0] m;
  logic w_d;
  logic w_q;
  assign c = delay_cfg;
  assign m = hwdata[2:0];
  // Address phase of a mode write; w_q marks its data phase
  always_comb w_d = hsel && htrans[1] && hready && hwrite && haddr[11:2] == 10'h110;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) w_q <= 1'b0;
    else w_q <= w_d;
  end
  a_mode_off: assert property (w_q && m == 3'h0 |-> ##2 c == '0)
    else $error("mode 0 left a delay on");
  a_fine_lim: assert property (w_q && m[2:1] == 2'h1 |-> ##2
    c.fine_en && c.fine_steps <= 8'h10 && c.low_jitter == $past(m[0], 2)
    && c.superfine_en == !$past(m[0], 2)) else $error("limited fine mode wrong");
  a_fine_full: assert property (w_q && m == 3'h4 |-> ##2
    c.fine_en && !c.superfine_en && !c.low_jitter) else $error("mode 4 wrong");
  a_both_on: assert property (w_q && m == 3'h6 |-> ##2
    c.fine_en && c.superfine_en && !c.low_jitter) else $error("mode 6 wrong");
  a_sf_range: assert property (c.superfine_steps <= 8'h80)
    else $error("superfine steps above 128");
  a_delay_sum: assert property (c.delay_fs ==
    c.fine_steps * 19'h6BD + c.superfine_steps * 19'hFA) else $error("delay sum wrong");
  a_fine_max: assert property (c.fine_steps <= 8'hC0)
    else $error("fine steps above 192");
  c_superfine: cover property (c.superfine_en);
  c_jitter: cover property (c.low_jitter);
  c_fine_top: cover property (c.fine_en && c.fine_steps == 8'hC0);
endmodule
bind sample_clock_delay_control scdc_sva #(.ADDR_W(ADDR_W)) u_scdc_sva (.*);
`default_nettype wire

// ### tb_sample_clock_delay_control.sv
// Bench for the clock delay register bank.
// Single word AHB-Lite transfers; hready follows hreadyout.
`timescale 1ns/1ps
`default_nettype none
module tb_sample_clock_delay_control;
  import clk_delay_pkg::*;
  logic clk = 0;
  logic resetn = 0;
  logic hsel = 0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 0;
  logic [31:0] hwdata = '0;
  logic clock_detected = 1;
  wire logic hready;
  wire logic hresp;
  logic [31:0] hrdata;
  delay_cfg_t cfg;
  int n_mismatch = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  sample_clock_delay_control u_sample_clock_delay_control (.clk(clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .clock_detected(clock_detected), .delay_cfg(cfg));
  // Wide enough for the whole settings struct, enables included
  task automatic chk(input string n, input logic [37:0] s, input logic [37:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rdy();
    int i;
    i = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      if (++i > 50) begin
        n_mismatch++;
        results();
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [37:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(n, {6'h00, r}, e);
  endtask
  task automatic t_reset();
    chk("delay_cfg", cfg, 38'h0);
    chk("hresp", {37'h0, hresp}, 38'h0);
    rd("mode", 12'h440, 38'h0);
    rd("superfine", 12'h444, 38'h0);
    rd("fine", 12'h448, 38'hC0);
    rd("state", 12'h46C, 38'h1);
    clock_detected <= 1'b0;
    rd("state_lost", 12'h46C, 38'h0);
    clock_detected <= 1'b1;
    rd("unmapped", 12'h400, 38'h0);
    $display("reset test done");
  endtask
  task automatic t_modes();
    delay_cfg_t x;
    // Counts kept inside every mode's valid range
    wr(12'h448, 32'h10);
    wr(12'h444, 32'h80);
    for (int m = 0; m < 8; m++) begin
      if (m == 1 || m == 5 || m == 7) continue;
      wr(12'h440, 32'(m));
      repeat (2) @(posedge clk);
      x = '0;
      x.fine_en = m inside {2, 3, 4, 6};
      x.superfine_en = m == 2 || m == 6;
      x.low_jitter = m == 3;
      x.fine_steps = x.fine_en ? 8'h10 : 8'h00;
      x.superfine_steps = x.superfine_en ? 8'h80 : 8'h00;
      x.delay_fs = x.fine_steps * 19'h6BD + x.superfine_steps * 19'hFA;
      chk("delay_cfg", cfg, x);
    end
    wr(12'h448, 32'hC0);
    wr(12'h440, 32'h4);
    repeat (2) @(posedge clk);
    chk("fine_steps", {30'h0, cfg.fine_steps}, 38'hC0);
    rd("fine", 12'h448, 38'hC0);
    $display("mode test done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_modes();
    results();
  end
endmodule
`default_nettype wire
